// ### rtl/thr_defs.svh
// offsets, field positions, reset values and codes of the high-event recorder
// assumes the includer works in 32-bit AXI4-Lite words, index * 4 = address
//
// How it works
// - event when temp[11:4] exceeds high limit
// - 8-bit binary count wraps 255 to 0
// - enable clear: count holds, events ignored
// - enable set: count plus one per event
// - count and stamps ignore host writes
// - seconds stamp holds BCD seconds, bits 6:0
// - minutes stamp holds BCD minutes, bits 6:0
// - select bit keeps first or last event
// - stamp clear write zeroes both stamps unless a capture falls in that cycle
// - bit seven of both stamps reads zero
`ifndef THR_DEFS_SVH
`define THR_DEFS_SVH

// register indices; byte address is four times the index
`define THR_IDX_COUNT      6'h1F
`define THR_IDX_STAMP_SEC  6'h20
`define THR_IDX_STAMP_MIN  6'h21
`define THR_IDX_CTRL       6'h30
`define THR_IDX_LIMIT      6'h31
`define THR_IDX_IRQ_STAT   6'h32
`define THR_IDX_IRQ_EN     6'h33
`define THR_IDX_IRQ_CLR    6'h34

// control register fields
`define THR_CTRL_EN_BIT    0
`define THR_CTRL_SEL_BIT   1
`define THR_CTRL_CLR_BIT   2

// interrupt status fields
`define THR_IRQ_EVENT_BIT  0
`define THR_IRQ_WRAP_BIT   1
`define THR_IRQ_W          2

// reset values
`define THR_RST_BYTE       8'h00
`define THR_RST_LIMIT      8'hFF
`define THR_RST_IRQ        2'h0
`define THR_COUNT_MAX      8'hFF

// bus answers
`define THR_RESP_OKAY      2'h0
`define THR_RESP_SLVERR    2'h2

`endif

// ### rtl/thr_pkg.sv
// types shared by the high-event recorder files
// assumes thr_defs.svh supplies the numbers
package thr_pkg;
  typedef logic [7:0]  thr_byte_t;  // one register byte
  typedef logic [6:0]  thr_bcd_t;   // two BCD digits, 00 to 59
  typedef logic [11:0] thr_temp_t;  // raw temperature reading
  typedef logic [1:0]  thr_resp_t;  // AXI response code
endpackage : thr_pkg

// ### rtl/thr_event_det.sv
// temperature-high comparator and event edge detector
// assumes temperature and limit are synchronous to the clock
`timescale 1ns/10ps
module thr_event_det (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire thr_pkg::thr_temp_t i_temp,
  input  wire thr_pkg::thr_byte_t i_limit,
  output logic                   o_event
);
  import thr_pkg::*;

  logic above;      // condition level
  logic above_reg;  // condition one cycle ago

  // upper byte of the reading against the limit
  assign above = (i_temp[11:4] > i_limit);

  // one event per rise, so a long hot spell counts once
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      above_reg <= 1'b0;
      o_event   <= 1'b0;
    end else begin
      above_reg <= above;
      o_event   <= above & ~above_reg;
    end
  end
endmodule : thr_event_det

// ### rtl/thr_axil_slave.sv
// AXI4-Lite slave front end: turns bus beats into local strobes
// assumes one write and one read outstanding, decode done by the includer
`timescale 1ns/10ps
`include "thr_defs.svh"
module thr_axil_slave #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_wr_en,
  output logic [5:0]             o_wr_idx,
  output logic [7:0]             o_wr_data,
  output logic [5:0]             o_rd_idx,
  input  wire logic [7:0]        i_rd_data,
  input  wire logic              i_rd_err,
  input  wire logic              i_wr_err
);
  import thr_pkg::*;

  logic have_aw_reg;  // write address held
  logic have_w_reg;   // write data held
  logic w_lane_reg;   // low byte lane was enabled
  logic rd_busy_reg;  // read address held, data pending

  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("thr_axil_slave: ADDR_W must be at least 8");
    end
  endgenerate

  // write channels taken in either order, response after both
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_awready   <= 1'b1;
      o_wready    <= 1'b1;
      have_aw_reg <= 1'b0;
      have_w_reg  <= 1'b0;
      w_lane_reg  <= 1'b0;
      o_wr_idx    <= 6'h00;
      o_wr_data   <= 8'h00;
      o_wr_en     <= 1'b0;
      o_bvalid    <= 1'b0;
      o_bresp     <= `THR_RESP_OKAY;
    end else begin
      o_wr_en <= 1'b0;
      if (i_awvalid && o_awready) begin
        o_wr_idx    <= i_awaddr[7:2];
        have_aw_reg <= 1'b1;
        o_awready   <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        // only the low lane carries register data
        o_wr_data  <= i_wdata[7:0];
        w_lane_reg <= i_wstrb[0];
        have_w_reg <= 1'b1;
        o_wready   <= 1'b0;
      end
      if (have_aw_reg && have_w_reg && !o_bvalid) begin
        // strobe goes out with the response; lane-less writes still answer
        // a write without the low lane answers but changes nothing
        o_wr_en     <= ~i_wr_err & w_lane_reg;
        o_bresp     <= i_wr_err ? `THR_RESP_SLVERR : `THR_RESP_OKAY;
        o_bvalid    <= 1'b1;
        have_aw_reg <= 1'b0;
        have_w_reg  <= 1'b0;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // read: address in, data registered one edge later
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready   <= 1'b1;
      rd_busy_reg <= 1'b0;
      o_rd_idx    <= 6'h00;
      o_rvalid    <= 1'b0;
      o_rdata     <= 32'h0000_0000;
      o_rresp     <= `THR_RESP_OKAY;
    end else begin
      if (i_arvalid && o_arready) begin
        o_rd_idx    <= i_araddr[7:2];
        rd_busy_reg <= 1'b1;
        o_arready   <= 1'b0;
      end
      if (rd_busy_reg && !o_rvalid) begin
        o_rdata     <= {24'h00_0000, i_rd_data};
        o_rresp     <= i_rd_err ? `THR_RESP_SLVERR : `THR_RESP_OKAY;
        o_rvalid    <= 1'b1;
        rd_busy_reg <= 1'b0;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule : thr_axil_slave

// ### rtl/thr_recorder.sv
// temperature-high event recorder: counter, seconds and minutes stamps
// assumes time inputs are live BCD from the clock core, synchronous to clk
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "thr_defs.svh"
module thr_recorder #(
  parameter int ADDR_W = 8
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_b,
  input  wire thr_pkg::thr_temp_t i_temp,
  input  wire thr_pkg::thr_bcd_t  i_time_sec,
  input  wire thr_pkg::thr_bcd_t  i_time_min,
  input  wire logic [ADDR_W-1:0]  i_awaddr,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  output logic [1:0]              o_bresp,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  input  wire logic [ADDR_W-1:0]  i_araddr,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  output logic                    o_irq
);
  import thr_pkg::*;

  // local register strobes from the bus front end
  logic      wr_en;
  logic [5:0] wr_idx;
  thr_byte_t wr_data;
  logic [5:0] rd_idx;
  thr_byte_t rd_data;
  logic      rd_err;
  logic      wr_err;

  // recorder state
  thr_byte_t count_reg;      // event count
  thr_bcd_t  sec_reg;        // seconds stamp
  thr_bcd_t  min_reg;        // minutes stamp
  logic      recorded_reg;   // a stamp is held since last clear
  logic      en_reg;         // recording enable
  logic      sel_reg;        // 1 keeps last event, 0 keeps first
  thr_byte_t limit_reg;      // high limit value
  logic [`THR_IRQ_W-1:0] irq_stat_reg; // sticky events
  logic [`THR_IRQ_W-1:0] irq_en_reg;   // interrupt enables

  // derived strobes
  logic hi_event;  // one-cycle temperature-high event
  logic count_ev;  // event taken by the counter
  logic capture;   // stamps load this cycle
  logic clr_pulse; // host stamp clear
  logic [`THR_IRQ_W-1:0] irq_set; // events for the status register

  thr_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_idx  (wr_idx),
    .o_wr_data (wr_data),
    .o_rd_idx  (rd_idx),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err),
    .i_wr_err  (wr_err)
  );

  thr_event_det u_det (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_temp    (i_temp),
    .i_limit   (limit_reg),
    .o_event   (hi_event)
  );

  // a disabled recorder sees no events at all
  assign count_ev  = hi_event & en_reg;
  // first mode stamps only the first event after a clear
  assign capture   = count_ev & (sel_reg | ~recorded_reg);
  assign clr_pulse = wr_en && (wr_idx == `THR_IDX_CTRL)
                     && wr_data[`THR_CTRL_CLR_BIT];

  // event counter; no host path writes it
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reg <= `THR_RST_BYTE;
    end else if (count_ev) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // stamps: a capture in the clear cycle wins, so that event is kept
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sec_reg      <= 7'h00;
      min_reg      <= 7'h00;
      recorded_reg <= 1'b0;
    end else if (capture) begin
      sec_reg      <= i_time_sec;
      min_reg      <= i_time_min;
      recorded_reg <= 1'b1;
    end else if (clr_pulse) begin
      sec_reg      <= 7'h00;
      min_reg      <= 7'h00;
      recorded_reg <= 1'b0;
    end
  end

  // writable control, limit and interrupt enable
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_reg     <= 1'b0;
      sel_reg    <= 1'b0;
      limit_reg  <= `THR_RST_LIMIT;
      irq_en_reg <= `THR_RST_IRQ;
    end else if (wr_en) begin
      if (wr_idx == `THR_IDX_CTRL) begin
        en_reg  <= wr_data[`THR_CTRL_EN_BIT];
        sel_reg <= wr_data[`THR_CTRL_SEL_BIT];
      end else if (wr_idx == `THR_IDX_LIMIT) begin
        limit_reg <= wr_data;
      end else if (wr_idx == `THR_IDX_IRQ_EN) begin
        irq_en_reg <= wr_data[`THR_IRQ_W-1:0];
      end
    end
  end

  // sticky status: set wins over a same-cycle clear
  assign irq_set[`THR_IRQ_EVENT_BIT] = count_ev;
  assign irq_set[`THR_IRQ_WRAP_BIT]  = count_ev
                                       && (count_reg == `THR_COUNT_MAX);
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat_reg <= `THR_RST_IRQ;
    end else if (wr_en && (wr_idx == `THR_IDX_IRQ_CLR)) begin
      irq_stat_reg <= (irq_stat_reg & ~wr_data[`THR_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // level interrupt, registered so the pin comes from a flop
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((irq_stat_reg | irq_set) & irq_en_reg);
    end
  end

  // read mux; stamp bit seven is a hard zero
  always_comb begin
    rd_data = 8'h00;
    rd_err  = 1'b0;
    if (rd_idx == `THR_IDX_COUNT) begin
      rd_data = count_reg;
    end else if (rd_idx == `THR_IDX_STAMP_SEC) begin
      rd_data = {1'b0, sec_reg};
    end else if (rd_idx == `THR_IDX_STAMP_MIN) begin
      rd_data = {1'b0, min_reg};
    end else if (rd_idx == `THR_IDX_CTRL) begin
      rd_data = {6'h00, sel_reg, en_reg};
    end else if (rd_idx == `THR_IDX_LIMIT) begin
      rd_data = limit_reg;
    end else if (rd_idx == `THR_IDX_IRQ_STAT) begin
      rd_data = {6'h00, irq_stat_reg};
    end else if (rd_idx == `THR_IDX_IRQ_EN) begin
      rd_data = {6'h00, irq_en_reg};
    end else if (rd_idx == `THR_IDX_IRQ_CLR) begin
      rd_data = 8'h00; // write-only, reads zero
    end else begin
      rd_err = 1'b1;
    end
  end

  // writes to read-only words are accepted but change nothing
  always_comb begin
    wr_err = 1'b1;
    if (wr_idx == `THR_IDX_COUNT
        || wr_idx == `THR_IDX_STAMP_SEC
        || wr_idx == `THR_IDX_STAMP_MIN
        || wr_idx == `THR_IDX_IRQ_STAT) begin
      wr_err = 1'b0;
    end else if (wr_idx >= `THR_IDX_CTRL
                 && wr_idx <= `THR_IDX_IRQ_CLR) begin
      wr_err = 1'b0;
    end
  end

  // checks next to the logic they guard
  logic [11:0] temp_q;  // reading one cycle back
  thr_byte_t   limit_q; // limit one cycle back
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      temp_q  <= 12'h000;
      limit_q <= 8'h00;
    end else begin
      temp_q  <= i_temp;
      limit_q <= limit_reg;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  event_cause_a: assert property (
    hi_event |-> (temp_q[11:4] > limit_q))
    else $error("event without temperature above limit");

  count_wrap_a: assert property (
    count_ev && count_reg == 8'hFF |=> count_reg == 8'h00)
    else $error("counter did not wrap to zero");

  count_hold_a: assert property (
    !en_reg |=> count_reg == $past(count_reg))
    else $error("counter moved while disabled");

  count_inc_a: assert property (
    hi_event && en_reg |=> count_reg == $past(count_reg) + 8'h01)
    else $error("counter did not step by one");

  ro_write_a: assert property (
    wr_en && wr_idx == `THR_IDX_STAMP_SEC && !capture && !clr_pulse
    |=> sec_reg == $past(sec_reg))
    else $error("host write changed seconds stamp");

  sec_capture_a: assert property (
    capture |=> sec_reg == $past(i_time_sec))
    else $error("seconds stamp not captured");

  min_capture_a: assert property (
    capture |=> min_reg == $past(i_time_min))
    else $error("minutes stamp not captured");

  first_keep_a: assert property (
    recorded_reg && !sel_reg && !clr_pulse
    |=> sec_reg == $past(sec_reg) && min_reg == $past(min_reg))
    else $error("first-event stamp overwritten");

  clear_sec_a: assert property (
    clr_pulse && !capture |=> sec_reg == 7'h00)
    else $error("stamp clear left seconds set");

  bit7_zero_a: assert property (
    o_rvalid && o_rresp == `THR_RESP_OKAY
    && (rd_idx == `THR_IDX_STAMP_SEC || rd_idx == `THR_IDX_STAMP_MIN)
    |-> !o_rdata[7])
    else $error("stamp bit seven read as one");

  clear_min_a: assert property (
    clr_pulse && !capture |=> min_reg == 7'h00 && !recorded_reg)
    else $error("stamp clear left minutes set");

  irq_level_a: assert property (
    |(irq_stat_reg & irq_en_reg) |=> o_irq)
    else $error("interrupt low with enabled status");

  first_event_c: cover property (capture && !sel_reg);
  last_event_c:  cover property (capture && sel_reg && recorded_reg);
  wrap_c:        cover property (irq_set[`THR_IRQ_WRAP_BIT]);
  clear_c:       cover property (clr_pulse ##1 hi_event);
endmodule : thr_recorder

// ### tb/thr_host_model.sv
// host side model: AXI4-Lite master for the recorder's register bus
// assumes one clock shared with the recorder; bench calls write and read
`timescale 1ns/10ps
module thr_host_model (
  input  wire logic        i_clk_sys,
  output logic [7:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  // idle bus from time zero
  initial begin
    o_awaddr  = 8'h00;
    o_awvalid = 1'b0;
    o_wdata   = 32'h0;
    o_wstrb   = 4'h0;
    o_wvalid  = 1'b0;
    o_bready  = 1'b0;
    o_araddr  = 8'h00;
    o_arvalid = 1'b0;
    o_rready  = 1'b0;
  end

  // one write; a freed payload is inverted so stale values cannot help
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    @(posedge i_clk_sys);
    o_awaddr  <= a;
    o_awvalid <= 1'b1;
    o_wdata   <= d;
    o_wstrb   <= 4'hF;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    forever begin
      @(posedge i_clk_sys);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
      if (i_bvalid) begin
        r = i_bresp;
        o_bready <= 1'b0;
        break;
      end
    end
  endtask : write

  // one read; rready held until rvalid is sampled high
  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    @(posedge i_clk_sys);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    forever begin
      @(posedge i_clk_sys);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~a;
      end
      if (i_rvalid) begin
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
        break;
      end
    end
  endtask : read
endmodule : thr_host_model

// ### tb/testbench.sv
// self-checking bench for the high-event recorder
// assumes host model tasks drive the bus; temperature and time come from here
`timescale 1ns/10ps
`include "thr_defs.svh"
module testbench;
  import thr_pkg::*;
  // byte addresses, four times the word index
  localparam logic [7:0] A_CNT = {`THR_IDX_COUNT, 2'b00};
  localparam logic [7:0] A_SEC = {`THR_IDX_STAMP_SEC, 2'b00};
  localparam logic [7:0] A_MIN = {`THR_IDX_STAMP_MIN, 2'b00};
  localparam logic [7:0] A_CTL = {`THR_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_LIM = {`THR_IDX_LIMIT, 2'b00};
  localparam logic [7:0] A_STA = {`THR_IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_IEN = {`THR_IDX_IRQ_EN, 2'b00};
  localparam logic [7:0] A_ICL = {`THR_IDX_IRQ_CLR, 2'b00};

  typedef struct packed {
    logic [7:0]  addr;   // target word
    logic [31:0] wdata;  // value written
    logic [31:0] rexp;   // value read back after it
    logic [1:0]  resp;   // answer to both beats
  } thr_row_s;
  // register table: read-only words stay untouched, writable words read back, the unmapped word answers SLVERR
  localparam thr_row_s ROWS [7] = '{
    '{A_CNT, 32'h55, 32'h0, `THR_RESP_OKAY},
    '{A_SEC, 32'h7F, 32'h0, `THR_RESP_OKAY},
    '{A_MIN, 32'h7F, 32'h0, `THR_RESP_OKAY},
    '{A_LIM, 32'h30, 32'h30, `THR_RESP_OKAY},
    '{A_IEN, 32'h01, 32'h01, `THR_RESP_OKAY},
    '{A_CTL, 32'h01, 32'h01, `THR_RESP_OKAY},
    '{8'hFC, 32'h12, 32'h0, `THR_RESP_SLVERR}};

  logic        clk_sys = 1'b0;       // 20 MHz system clock
  logic        rst_b   = 1'b0;       // active-low reset
  thr_temp_t   temp    = 12'h000;    // temperature reading
  thr_bcd_t    tsec    = 7'h00;      // live seconds
  thr_bcd_t    tmin    = 7'h00;      // live minutes
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #25 clk_sys = ~clk_sys;

  thr_recorder #(.ADDR_W(8)) i_dut (
    .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_temp(temp),
    .i_time_sec(tsec), .i_time_min(tmin),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_irq(irq));

  thr_host_model i_host (
    .i_clk_sys(clk_sys), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb),
    .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid),
    .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
    .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
    .i_rvalid(rvalid), .o_rready(rready));

  // compare one value, count it, report a miss at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // read a word and compare its data
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    i_host.read(a, d, r);
    chk(d, exp);
  endtask : rd_chk

  // n rising crossings; the low phase sits exactly at the limit
  task automatic events(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      temp <= 12'h310;
      repeat (3) @(posedge clk_sys);
      temp <= 12'h300;
      repeat (2) @(posedge clk_sys);
    end
  endtask : events

  // verdict and end of run
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // watchdog: the whole run needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd_chk(A_CNT, 32'h0);
    rd_chk(A_LIM, 32'hFF);
    chk({31'h0, irq}, 32'h0);
    $display("done: reset values");
    foreach (ROWS[i]) begin
      i_host.write(ROWS[i].addr, ROWS[i].wdata, r);
      chk({30'h0, r}, {30'h0, ROWS[i].resp});
      i_host.read(ROWS[i].addr, d, r);
      chk(d, ROWS[i].rexp);
      chk({30'h0, r}, {30'h0, ROWS[i].resp});
    end
    $display("done: register table");
    // first-event mode: the second crossing must not move the stamps
    tsec <= 7'h25;
    tmin <= 7'h47;
    events(1);
    tsec <= 7'h59;
    tmin <= 7'h33;
    events(1);
    rd_chk(A_CNT, 32'h2);
    rd_chk(A_SEC, 32'h25);
    rd_chk(A_MIN, 32'h47);
    chk({31'h0, irq}, 32'h1);
    // last-event mode
    i_host.write(A_CTL, 32'h03, r);
    tmin <= 7'h59;
    events(1);
    rd_chk(A_CNT, 32'h3);
    rd_chk(A_SEC, 32'h59);
    rd_chk(A_MIN, 32'h59);
    $display("done: stamp modes");
    // stamp clear keeps the count
    i_host.write(A_CTL, 32'h07, r);
    rd_chk(A_SEC, 32'h0);
    rd_chk(A_MIN, 32'h0);
    rd_chk(A_CTL, 32'h03);
    // disabled: crossings ignored
    i_host.write(A_CTL, 32'h00, r);
    events(2);
    rd_chk(A_CNT, 32'h3);
    rd_chk(A_SEC, 32'h0);
    $display("done: clear and disable");
    // interrupt clear, then mask during wrap
    i_host.write(A_ICL, 32'h03, r);
    rd_chk(A_STA, 32'h0);
    chk({31'h0, irq}, 32'h0);
    i_host.write(A_IEN, 32'h00, r);
    i_host.write(A_CTL, 32'h01, r);
    tsec <= 7'h11;
    tmin <= 7'h22;
    events(253);
    rd_chk(A_CNT, 32'h0);
    rd_chk(A_SEC, 32'h11);
    rd_chk(A_STA, 32'h03);
    chk({31'h0, irq}, 32'h0);
    i_host.write(A_IEN, 32'h02, r);
    rd_chk(A_IEN, 32'h02);
    chk({31'h0, irq}, 32'h1);
    $display("done: wrap and interrupt");
    // reset in mid-run restores the defaults
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd_chk(A_CNT, 32'h0);
    rd_chk(A_MIN, 32'h0);
    rd_chk(A_LIM, 32'hFF);
    $display("done: second reset");
    close_out();
  end
endmodule : testbench
